/* design/cam_defs.svh */
// constants of the CAN acceptance-mask and interrupt block
// assumes inclusion by bare name from the package and the top module
`ifndef CAM_DEFS_SVH
`define CAM_DEFS_SVH

// ==========================================================
// register byte addresses on the APB
`define CAM_AW          8
`define CAM_OFS_GMH     8'h00
`define CAM_OFS_GML     8'h04
`define CAM_OFS_BMH     8'h08
`define CAM_OFS_BML     8'h0C
`define CAM_OFS_IEN     8'h10
`define CAM_OFS_BUFFER_PENDING_FLAGS    8'h14
`define CAM_OFS_BUFFER_CLEAR_BITS    8'h18
`define CAM_OFS_BUFFER_CODE_ENABLE    8'h1C
`define CAM_OFS_NSC     8'h20
`define CAM_OFS_CFG     8'h24

// ==========================================================
// field positions and widths
`define CAM_REG_W       16
`define CAM_KEY_W       32
`define CAM_ERR_BIT     15
`define CAM_BUF_N       15
`define CAM_STD_LSB     19
`define CAM_IRQ_BIT     4
`define CAM_NS_LSB      5
`define CAM_NS_MSB      7
`define CAM_EIT_BIT     0
`define CAM_IST_W       4

// ==========================================================
// reset and fill values
`define CAM_RST_16      16'h0000
`define CAM_ZERO_32     32'h0000_0000
`define CAM_IST_NONE    4'h0

`endif

/* design/cam_filt_if.sv */
// carrier between the top module and the acceptance comparator
// assumes cam_pkg compiled first
interface cam_filt_if;
    import cam_pkg::*;

    cam_key_t in_key;
    cam_key_t buf_key;
    cam_key_t mask;
    logic     ext;
    logic     hit;
    cam_key_t merged;

    modport filt (
        input  in_key,
        input  buf_key,
        input  mask,
        input  ext,
        output hit,
        output merged
    );

    modport user (
        output in_key,
        output buf_key,
        output mask,
        output ext,
        input  hit,
        input  merged
    );
endinterface : cam_filt_if

/* design/cam_filter.sv */
// acceptance comparator: one bit slice per key bit
// assumes keys packed as {id_hi11, srr_rtr, ide, id_lo18, extended_remote_mask}
`include "cam_defs.svh"

module cam_filter (
    cam_filt_if.filt f
);
    import cam_pkg::*;

    wire logic [`CAM_KEY_W-1:0] eq;
    wire logic [`CAM_KEY_W-1:0] mrg;

    // ======================================================
    // per-bit compare and overwrite
    genvar i;
    generate
        for (i = 0; i < `CAM_KEY_W; i++) begin : g_bit
            // standard frames only use the top slice of the mask
            localparam bit USED_STD = (i >= `CAM_STD_LSB);
            wire logic used;
            wire logic dc;
            assign used = f.ext | USED_STD;
            assign dc = used & f.mask[i];
            // mask 1 ignores the bit, 0 demands equality
            assign eq[i] = ~used | dc
                         | (f.in_key[i] == f.buf_key[i]);
            // don't-care bits take the incoming value
            assign mrg[i] = dc ? f.in_key[i] : f.buf_key[i];
        end
    endgenerate

    assign f.hit = &eq;
    assign f.merged = mrg;
endmodule : cam_filter

/* design/cam_pkg.sv */
// types shared by the acceptance-mask and interrupt block
// assumes cam_defs.svh on the include path
`include "cam_defs.svh"

package cam_pkg;

    // ======================================================
    // node status codes reported in the status field
    typedef logic [2:0] cam_ns_t;
    localparam cam_ns_t CAM_NS_OFF     = 3'h0;
    localparam cam_ns_t CAM_NS_ACTIVE  = 3'h2;
    localparam cam_ns_t CAM_NS_WARN    = 3'h3;
    localparam cam_ns_t CAM_NS_PASSIVE = 3'h4;
    localparam cam_ns_t CAM_NS_BUSOFF  = 3'h6;

    typedef logic [`CAM_KEY_W-1:0] cam_key_t;
    typedef logic [`CAM_REG_W-1:0] cam_reg_t;

    // ======================================================
    // whole state of the top module
    typedef struct packed {
        cam_reg_t  gm_hi;
        cam_reg_t  gm_lo;
        cam_reg_t  bm_hi;
        cam_reg_t  bm_lo;
        cam_reg_t  buffer_irq_enable;
        cam_reg_t  buffer_pending_flags;
        cam_reg_t  buffer_code_enable;
        logic      error_interrupt_type;
        cam_ns_t   ns;
        logic      pready;
        logic      pslverr;
        logic [31:0] prdata;
        logic      irq;
        logic      acc_valid;
        logic      acc_match;
        cam_key_t  acc_key;
    } cam_state_t;

endpackage : cam_pkg

/* design/cam_top.sv */
// CAN acceptance masks, interrupt pending/enable and code logic
// assumes an APB master on pclk and a frame engine on the same clock
//
// Design decisions made here: the APB slave port and the register addresses.
`include "cam_defs.svh"

module cam_top (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`CAM_AW-1:0]      paddr,
    input  wire logic [31:0]             pwdata,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr,
    // frame engine: acceptance check
    input  wire logic                    frm_check,
    input  wire logic                    frm_ext,
    input  wire logic                    frm_buf14,
    input  wire cam_pkg::cam_key_t       frm_key,
    input  wire cam_pkg::cam_key_t       buf_key,
    output logic                         acc_valid,
    output logic                         acc_match,
    output cam_pkg::cam_key_t            acc_key,
    // frame engine: buffer and error events
    input  wire logic [`CAM_BUF_N-1:0]   buf_tx_ok,
    input  wire logic [`CAM_BUF_N-1:0]   buf_rx_ok,
    input  wire logic                    bus_error,
    input  wire logic                    err_cnt_inc,
    input  wire cam_pkg::cam_ns_t        node_state,
    // CPU interrupt
    output logic                         cpu_irq
);
    import cam_pkg::*;

    cam_state_t s_q;
    cam_state_t s_d;

    cam_filt_if fif ();

    // ======================================================
    // acceptance comparator
    cam_filter u_filter (
        .f (fif.user)
    );

    // buffer 14 alone sees the basic mask
    assign fif.mask = frm_buf14 ? {s_q.bm_hi, s_q.bm_lo}
                                : {s_q.gm_hi, s_q.gm_lo};
    assign fif.in_key = frm_key;
    assign fif.buf_key = buf_key;
    assign fif.ext = frm_ext;

    // ======================================================
    // interrupt code: error first, then buffer 0 upward
    logic [`CAM_REG_W-1:0] code_act;
    logic                  code_req;
    logic [`CAM_IST_W-1:0] code_ist;

    always_comb begin
        code_act = s_q.buffer_pending_flags & s_q.buffer_code_enable;
        code_req = |code_act;
        code_ist = `CAM_IST_NONE;
        // walk downward so the lowest buffer number wins
        for (int i = `CAM_BUF_N - 1; i >= 0; i--) begin
            if (code_act[i]) begin
                code_ist = `CAM_IST_W'(i + 1);
            end
        end
        if (code_act[`CAM_ERR_BIT]) begin
            code_ist = `CAM_IST_NONE;
        end
    end

    // ======================================================
    // status word as read by software
    logic [31:0] nsc_word;

    always_comb begin
        nsc_word = `CAM_ZERO_32;
        nsc_word[`CAM_NS_MSB:`CAM_NS_LSB] = s_q.ns;
        nsc_word[`CAM_IRQ_BIT] = code_req;
        nsc_word[`CAM_IST_W-1:0] = code_ist;
    end

    // ======================================================
    // error event selection
    logic err_set;
    logic ns_moved;

    always_comb begin
        ns_moved = err_cnt_inc & (node_state != s_q.ns);
        // type 1 suppresses errors that leave the node status alone
        if (s_q.error_interrupt_type) begin
            err_set = ns_moved;
        end else begin
            err_set = bus_error | ns_moved;
        end
    end

    // ======================================================
    // APB decode helpers
    logic                  setup;
    logic                  wr_acc;
    logic                  mapped;
    logic [31:0]           rd_word;
    logic [`CAM_REG_W-1:0] clr;
    logic [`CAM_REG_W-1:0] set;

    always_comb begin
        setup = psel & ~penable;
        // a write lands only on the edge that completes the access
        wr_acc = psel & penable & s_q.pready & pwrite;
        mapped = 1'b1;
        rd_word = `CAM_ZERO_32;
        unique case (paddr)
            `CAM_OFS_GMH:  rd_word[`CAM_REG_W-1:0] = s_q.gm_hi;
            `CAM_OFS_GML:  rd_word[`CAM_REG_W-1:0] = s_q.gm_lo;
            `CAM_OFS_BMH:  rd_word[`CAM_REG_W-1:0] = s_q.bm_hi;
            `CAM_OFS_BML:  rd_word[`CAM_REG_W-1:0] = s_q.bm_lo;
            `CAM_OFS_IEN:  rd_word[`CAM_REG_W-1:0] = s_q.buffer_irq_enable;
            `CAM_OFS_BUFFER_PENDING_FLAGS: rd_word[`CAM_REG_W-1:0] = s_q.buffer_pending_flags;
            // clear register is write only and reads as zero
            `CAM_OFS_BUFFER_CLEAR_BITS: rd_word = `CAM_ZERO_32;
            `CAM_OFS_BUFFER_CODE_ENABLE: rd_word[`CAM_REG_W-1:0] = s_q.buffer_code_enable;
            `CAM_OFS_NSC:  rd_word = nsc_word;
            `CAM_OFS_CFG:  rd_word[`CAM_EIT_BIT] = s_q.error_interrupt_type;
            default:       mapped = 1'b0;
        endcase
        clr = `CAM_RST_16;
        if (wr_acc && paddr == `CAM_OFS_BUFFER_CLEAR_BITS) begin
            // only a plain write clears; no read side effect exists
            clr = pwdata[`CAM_REG_W-1:0];
        end
        set = `CAM_RST_16;
        set[`CAM_BUF_N-1:0] = buf_tx_ok | buf_rx_ok;
        set[`CAM_ERR_BIT] = err_set;
    end

    // ======================================================
    // next state
    always_comb begin
        s_d = s_q;

        // APB: answer in the first access cycle, no wait states
        s_d.pready = setup;
        s_d.pslverr = setup & ~mapped;
        if (setup) begin
            s_d.prdata = rd_word;
        end

        if (wr_acc) begin
            unique case (paddr)
                `CAM_OFS_GMH:  s_d.gm_hi = pwdata[`CAM_REG_W-1:0];
                `CAM_OFS_GML:  s_d.gm_lo = pwdata[`CAM_REG_W-1:0];
                `CAM_OFS_BMH:  s_d.bm_hi = pwdata[`CAM_REG_W-1:0];
                `CAM_OFS_BML:  s_d.bm_lo = pwdata[`CAM_REG_W-1:0];
                `CAM_OFS_IEN:  s_d.buffer_irq_enable = pwdata[`CAM_REG_W-1:0];
                `CAM_OFS_BUFFER_CODE_ENABLE: s_d.buffer_code_enable = pwdata[`CAM_REG_W-1:0];
                `CAM_OFS_CFG:  s_d.error_interrupt_type = pwdata[`CAM_EIT_BIT];
                default: begin
                end
            endcase
        end

        // a new event in the clearing cycle survives the clear
        s_d.buffer_pending_flags = (s_q.buffer_pending_flags & ~clr) | set;
        s_d.ns = node_state;

        // interrupt is decoded from the next flags, so it changes on the same edge as the flags
        s_d.irq = |(s_d.buffer_pending_flags & s_q.buffer_irq_enable);

        // acceptance result, one cycle after the check strobe
        s_d.acc_valid = frm_check;
        if (frm_check) begin
            s_d.acc_match = fif.hit;
            s_d.acc_key = fif.merged;
        end
    end

    // ======================================================
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // ======================================================
    // outputs straight from the state flops
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign acc_valid = s_q.acc_valid;
    assign acc_match = s_q.acc_match;
    assign acc_key = s_q.acc_key;
    assign cpu_irq = s_q.irq;
endmodule : cam_top

/* verification/cam_checker.sv */
// port assertions for cam_top
// assumes one clock pclk and asynchronous presetn
`include "cam_defs.svh"

module cam_checker (
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic [`CAM_AW-1:0]  paddr,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire logic                frm_check,
    input wire logic                frm_ext,
    input wire cam_pkg::cam_key_t   frm_key,
    input wire cam_pkg::cam_key_t   buf_key,
    input wire logic                acc_valid,
    input wire logic                acc_match,
    input wire cam_pkg::cam_key_t   acc_key
);
    timeunit 1ns;
    timeprecision 100ps;
    import cam_pkg::*;
    // ====================================
    // acceptance and bus relations
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    acc_answer_a: assert property (frm_check |=> acc_valid)
        else $error("no answer after check");
    acc_idle_a: assert property (!frm_check |=> !acc_valid)
        else $error("answer without check");
    acc_hold_a: assert property (!frm_check |=> $stable(acc_match))
        else $error("match changed without check");
    ext_equal_a: assert property (frm_check && frm_ext &&
        frm_key == buf_key |=> acc_match && acc_key == $past(buf_key))
        else $error("equal extended key refused");
    std_equal_a: assert property (frm_check && !frm_ext &&
        frm_key[31:19] == buf_key[31:19] |=> acc_match)
        else $error("equal standard id refused");
    ready_setup_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_once_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    bad_addr_a: assert property (pready && paddr > `CAM_OFS_CFG
        |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    good_addr_a: assert property (pready && paddr <= `CAM_OFS_CFG &&
        paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped access refused");
    upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    cover property (frm_check ##1 acc_match);
    cover property (frm_check ##1 !acc_match);
    cover property (pready && pslverr);
endmodule : cam_checker

bind cam_top cam_checker u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frm_check(frm_check),
    .frm_ext(frm_ext), .frm_key(frm_key), .buf_key(buf_key),
    .acc_valid(acc_valid), .acc_match(acc_match), .acc_key(acc_key));

/* verification/cam_fe_model.sv */
// frame engine stand-in: reports good tx or rx of one buffer
// assumes requests raised by the bench for one pclk cycle
module cam_fe_model (
    input  wire logic        pclk,
    input  wire logic        ev_go,
    input  wire logic        ev_tx,
    input  wire logic [3:0]  ev_idx,
    output logic      [14:0] buf_tx_ok,
    output logic      [14:0] buf_rx_ok
);
    timeunit 1ns;
    timeprecision 100ps;
    // ====================================
    // one-cycle completion pulses
    initial begin
        buf_tx_ok = '0;
        buf_rx_ok = '0;
    end
    always @(posedge pclk) begin
        buf_tx_ok <= (ev_go && ev_tx) ? 15'd1 << ev_idx : 15'd0;
        buf_rx_ok <= (ev_go && !ev_tx) ? 15'd1 << ev_idx : 15'd0;
    end
endmodule : cam_fe_model

/* verification/can_accept_mask_and_irq_test.sv */
// self-checking bench for cam_top
// assumes design, checker and frame engine model compiled first
`include "cam_defs.svh"

module can_accept_mask_and_irq_test;
    timeunit 1ns;
    timeprecision 100ps;
    import cam_pkg::*;
    localparam cam_key_t K = 32'hA5C3_5A3C;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic frm_check = 0, frm_ext = 0, frm_buf14 = 0, bus_error = 0;
    logic err_cnt_inc = 0, ev_go = 0, ev_tx = 0;
    logic pready, pslverr, acc_valid, acc_match, cpu_irq;
    logic [3:0] ev_idx = '0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic [14:0] buf_tx_ok, buf_rx_ok;
    cam_key_t frm_key = '0, buf_key = K, acc_key;
    cam_ns_t node_state = '0;
    int fails = 0, cmp_count = 0;
    always #12.5 pclk = ~pclk;
    cam_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .frm_check(frm_check), .frm_ext(frm_ext),
        .frm_buf14(frm_buf14), .frm_key(frm_key), .buf_key(buf_key),
        .acc_valid(acc_valid), .acc_match(acc_match), .acc_key(acc_key),
        .buf_tx_ok(buf_tx_ok), .buf_rx_ok(buf_rx_ok),
        .bus_error(bus_error), .err_cnt_inc(err_cnt_inc),
        .node_state(node_state), .cpu_irq(cpu_irq));
    cam_fe_model FE (.pclk(pclk), .ev_go(ev_go), .ev_tx(ev_tx),
        .ev_idx(ev_idx), .buf_tx_ok(buf_tx_ok), .buf_rx_ok(buf_rx_ok));
    // ====================================
    // shared tasks
    task wrap_up();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    task chk(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] rd, output logic er);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1;
        n = 0;
        // pready is read as sampled at this edge, before it updates
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fails++;
            wrap_up();
        end
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1, a, d, r, e);
    endtask : wr
    task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(0, a, 0, r, e);
        chk(nm, r, x);
    endtask : rd_chk
    task cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : cyc
    // one check: ext, buffer14, incoming key, expected match and key
    task acc(input logic x, b, input cam_key_t f, input logic m,
             input cam_key_t ek);
        @(posedge pclk);
        {frm_check, frm_ext, frm_buf14, frm_key} <= {1'b1, x, b, f};
        @(posedge pclk);
        frm_check <= 0;
        #1;
        chk("acc_match", 32'(acc_match), 32'(m));
        if (m && x) chk("acc_key", acc_key, ek);
    endtask : acc
    task ev(input logic tx, input logic [3:0] i);
        @(posedge pclk);
        {ev_go, ev_tx, ev_idx} <= {1'b1, tx, i};
        @(posedge pclk);
        ev_go <= 0;
        cyc(3);
    endtask : ev
    task err_ev(input logic inc, input cam_ns_t ns);
        @(posedge pclk);
        {bus_error, err_cnt_inc, node_state} <= {!inc, inc, ns};
        @(posedge pclk);
        {bus_error, err_cnt_inc} <= 2'b00;
        cyc(3);
    endtask : err_ev
    // ====================================
    // scenarios
    task s_reset();
        logic [31:0] r;
        logic e;
        for (int a = 0; a <= 'h24; a += 4)
            if (a != 'h18) rd_chk("reset", 8'(a), 0);
        apb(0, 8'h28, 32'hFFFF_FFFF, r, e);
        chk("unmapped err", 32'(e), 1);
    endtask : s_reset
    task s_mask();
        wr(`CAM_OFS_GMH, 32'h0000_0010);
        wr(`CAM_OFS_GML, 32'h0000_0003);
        acc(1, 0, K ^ 32'h0000_0003, 1, K ^ 32'h0000_0003);
        acc(1, 0, K ^ 32'h0000_0004, 0, K);
        acc(1, 0, K ^ 32'h0010_0000, 1, K ^ 32'h0010_0000);
        acc(0, 0, K ^ 32'h0017_FFFF, 1, K);
        acc(0, 0, K ^ 32'h0020_0000, 0, K);
        acc(1, 1, K ^ 32'h0000_0001, 0, K);
        wr(`CAM_OFS_BML, 32'h0000_0001);
        acc(1, 1, K ^ 32'h0000_0001, 1, K ^ 32'h0000_0001);
        acc(0, 1, K ^ 32'h0008_0000, 0, K);
    endtask : s_mask
    task s_irq();
        wr(`CAM_OFS_IEN, 32'h0000_0008);
        wr(`CAM_OFS_BUFFER_CODE_ENABLE, 32'h0000_4008);
        ev(0, 3);
        ev(1, 14);
        rd_chk("pending", `CAM_OFS_BUFFER_PENDING_FLAGS, 32'h0000_4008);
        chk("irq on", 32'(cpu_irq), 1);
        rd_chk("code b3", `CAM_OFS_NSC, 32'h0000_0014);
        wr(`CAM_OFS_BUFFER_CODE_ENABLE, 32'h0000_4000);
        rd_chk("code b14", `CAM_OFS_NSC, 32'h0000_001F);
        wr(`CAM_OFS_BUFFER_CLEAR_BITS, 32'h0000_0008);
        cyc(3);
        rd_chk("clear b3", `CAM_OFS_BUFFER_PENDING_FLAGS, 32'h0000_4000);
        chk("irq off", 32'(cpu_irq), 0);
        wr(`CAM_OFS_BUFFER_CLEAR_BITS, 32'h0000_4000);
    endtask : s_irq
    task s_err();
        cam_ns_t ns_tab [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h6};
        err_ev(0, 3'h0);
        rd_chk("err set", `CAM_OFS_BUFFER_PENDING_FLAGS, 32'h0000_8000);
        chk("err masked", 32'(cpu_irq), 0);
        wr(`CAM_OFS_IEN, 32'h0000_8000);
        cyc(3);
        chk("err irq", 32'(cpu_irq), 1);
        wr(`CAM_OFS_BUFFER_CODE_ENABLE, 32'h0000_8001);
        ev(0, 0);
        rd_chk("code err", `CAM_OFS_NSC, 32'h0000_0010);
        wr(`CAM_OFS_BUFFER_CLEAR_BITS, 32'h0000_0001);
        rd_chk("err kept", `CAM_OFS_BUFFER_PENDING_FLAGS, 32'h0000_8000);
        wr(`CAM_OFS_BUFFER_CLEAR_BITS, 32'h0000_8000);
        rd_chk("err clear", `CAM_OFS_BUFFER_PENDING_FLAGS, 32'h0000_0000);
        foreach (ns_tab[i]) begin
            node_state <= ns_tab[i];
            cyc(2);
            rd_chk("ns", `CAM_OFS_NSC, 32'({ns_tab[i], 5'h00}));
        end
        wr(`CAM_OFS_CFG, 32'h0000_0001);
        err_ev(0, 3'h6);
        rd_chk("type1 bus", `CAM_OFS_BUFFER_PENDING_FLAGS, 32'h0000_0000);
        err_ev(1, 3'h3);
        rd_chk("type1 inc", `CAM_OFS_BUFFER_PENDING_FLAGS, 32'h0000_8000);
    endtask : s_err
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        s_reset();
        s_mask();
        s_irq();
        s_err();
        wrap_up();
    end
endmodule : can_accept_mask_and_irq_test
